/* bit_sync.sv */
// two-flop synchroniser for single-bit levels
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule

`default_nettype wire

/* dac_cmd_cfg.svh */
// constants for the dual converter command block
`ifndef DAC_CMD_CFG_SVH
`define DAC_CMD_CFG_SVH

`define FRAME_BITS      24
`define FRAME_CNT_W     5
`define CMD_HI          21
`define CMD_LO          19
`define ADDR_HI         18
`define ADDR_LO         16
`define DATA_HI         15
`define DATA_LO         0
`define PMODE_HI        5
`define PMODE_LO        4
`define SEL_B_BIT       1
`define SEL_A_BIT       0
`define RST_DEPTH_BIT   0

`define CMD_WR_IN       3'h0
`define CMD_UPD_OUT     3'h1
`define CMD_WR_UPD_ALL  3'h2
`define CMD_WR_UPD_N    3'h3
`define CMD_POWER       3'h4
`define CMD_SOFT_RST    3'h5
`define CMD_MASK_SETUP  3'h6
`define CMD_RESERVED    3'h7

`define ADDR_CHAN_A     3'h0
`define ADDR_CHAN_B     3'h1
`define ADDR_BOTH       3'h7

`define PMODE_NORMAL    2'h0
`define PMODE_1K_GND    2'h1
`define PMODE_100K_GND  2'h2
`define PMODE_HIGH_Z    2'h3

`define CODE_RST        16'h0000
`define MASK_RST        2'h0
`define SYNC_STAGES     2

`endif

/* dac_cmd_checker.sv */
// concurrent checks on the converter block ports
`timescale 1ns/10ps
`default_nettype none
module dac_cmd_checker #(
  parameter int CHANNELS = 2
) (
  input wire logic                       mclk_in,
  input wire logic                       rst_in,
  input wire logic                       frame_sel_n_in,
  input wire logic                       load_strobe_n_in,
  input wire logic [CHANNELS-1:0][15:0] dac_code_out,
  input wire logic [CHANNELS-1:0][15:0] input_code_out,
  input wire logic [CHANNELS-1:0][1:0]  power_mode_out,
  input wire logic [CHANNELS-1:0]       sync_update_mask_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [4:0] idle_r;
  // counts cycles since frame select was last seen low
  always_ff @(posedge mclk_in) begin
    if (rst_in) idle_r <= 5'h1F;
    else if (!frame_sel_n_in) idle_r <= 5'h00;
    else if (idle_r != 5'h1F) idle_r <= idle_r + 5'h01;
  end
  reset_clear_a: assert property ($fell(rst_in) |-> dac_code_out == '0 && sync_update_mask_out == '0)
    else $error("outputs not clear after reset");
  copy_src_a: assert property (
    $changed(dac_code_out[0]) |-> dac_code_out[0] == $past(input_code_out[0]) || dac_code_out[0] == '0)
    else $error("output code not taken from input");
  frame_gate_a: assert property (
    $changed(input_code_out) || $changed(power_mode_out) || $changed(sync_update_mask_out) |-> idle_r < 5'h0C)
    else $error("state changed with no frame");
  power_code_a: assert property ($changed(power_mode_out) && power_mode_out != '0 |-> $stable(dac_code_out))
    else $error("power change touched output code");
  power_only_a: assert property (
    $changed(power_mode_out) && power_mode_out != '0 |-> $stable(input_code_out) && $stable(sync_update_mask_out))
    else $error("power command touched other state");
  mask_only_a: assert property (
    $changed(sync_update_mask_out) && sync_update_mask_out != '0 |-> $stable(input_code_out) && $stable(power_mode_out))
    else $error("mask setup touched other state");
  strobe_copy_a: assert property (
    (!load_strobe_n_in && $stable(input_code_out))[*5] |-> dac_code_out == input_code_out)
    else $error("strobe low did not copy inputs");
  masked_copy_a: assert property (
    (sync_update_mask_out[0] && $stable(input_code_out[0]))[*4] |-> dac_code_out[0] == input_code_out[0])
    else $error("masked channel not updated");
  cover property (!load_strobe_n_in && $changed(dac_code_out));
  cover property ($changed(power_mode_out));
  cover property ($changed(sync_update_mask_out) && sync_update_mask_out != '0);
endmodule
bind dual_dac_command_control dac_cmd_checker #(.CHANNELS(CHANNELS)) chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .frame_sel_n_in(frame_sel_n_in), .load_strobe_n_in(load_strobe_n_in),
  .dac_code_out(dac_code_out), .input_code_out(input_code_out), .power_mode_out(power_mode_out),
  .sync_update_mask_out(sync_update_mask_out));
`default_nettype wire

/* dac_cmd_pkg.sv */
// types for the dual converter command block
package dac_cmd_pkg;

  typedef logic [1:0]  pmode_t;
  typedef logic [15:0] code_t;

  typedef struct packed {
    logic [1:0]  pad;
    logic [2:0]  cmd;
    logic [2:0]  addr;
    logic [15:0] data;
  } frame_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_APPLY = 3'b100
  } exec_state_e;

endpackage

/* dual_dac_command_control.sv */
// serial frame decode and register control of a dual 16-bit converter
//
// Contract
// - falling-edge sampling, msb first, execute on 24th
// - frame: two pad, command, address, data
// - address 000 A, 001 B, 111 both
// - commands 000-011 write, update, write-update
// - early frame-select rise discards frame entirely
// - command 101 is software reset, bit 0 depth
// - shallow clears codes; deep also mask, power
// - reset ignores address and data bits 15-1
// - command 100 sets power, bits 5:4, selects 1:0
// - modes normal, 1k ground, 100k ground, high-z
// - unselected channels keep their power state
// - mode 00 powers selected channels back up
// - power-up shows input if strobe low, else held
// - power-down leaves output register untouched
// - input register loads only on valid write
// - strobe high holds outputs; low copies inputs
// - output reloads only when input changed since
// - mask bit 1 updates after every valid frame
// - command 110 loads 2-bit mask, resets zero
`include "dac_cmd_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module dual_dac_command_control
  import dac_cmd_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  input  wire logic                sclk_in,
  input  wire logic                frame_sel_n_in,
  input  wire logic                din_in,
  input  wire logic                load_strobe_n_in,
  output logic [CHANNELS-1:0][15:0] dac_code_out,
  output logic [CHANNELS-1:0][15:0] input_code_out,
  output logic [CHANNELS-1:0][1:0]  power_mode_out,
  output logic [CHANNELS-1:0]       sync_update_mask_out
);

  // ---------------- link domain (serial clock, falling edge) ----------------
  logic [`FRAME_BITS-1:0]  shift_r;
  logic [`FRAME_CNT_W-1:0] bit_cnt_r;
  frame_s                  frame_hold_r;
  logic                    frame_tog_r;
  logic                    last_bit;

  assign last_bit = (bit_cnt_r == `FRAME_CNT_W'(`FRAME_BITS - 1));

  // frame select high clears the partial frame; the serial clock may stop
  // between frames, so the frame's own signal does the clearing
  always_ff @(negedge sclk_in or posedge frame_sel_n_in) begin
    if (frame_sel_n_in) begin
      bit_cnt_r <= '0;
      shift_r   <= '0;
    end else if (bit_cnt_r != `FRAME_CNT_W'(`FRAME_BITS)) begin
      shift_r   <= {shift_r[`FRAME_BITS-2:0], din_in};
      bit_cnt_r <= bit_cnt_r + `FRAME_CNT_W'(1);
    end
  end

  // the hold word is stable for a whole frame time after the toggle moves,
  // far longer than the three system cycles the crossing needs
  always_ff @(negedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_tog_r  <= 1'b0;
      frame_hold_r <= '0;
    end else if (!frame_sel_n_in && last_bit) begin
      frame_hold_r <= frame_s'({shift_r[`FRAME_BITS-2:0], din_in});
      frame_tog_r  <= ~frame_tog_r;
    end
  end

  // ---------------- system domain ----------------
  logic        tog_sync;
  logic        strobe_n_sync;
  logic        tog_prev_r;
  logic        frame_pulse;
  exec_state_e state_r;
  frame_s      word_r;

  bit_sync #(.WIDTH(1)) u_tog_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (frame_tog_r),
    .q_out   (tog_sync)
  );

  bit_sync #(.WIDTH(1)) u_strobe_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (load_strobe_n_in),
    .q_out   (strobe_n_sync)
  );

  assign frame_pulse = tog_sync ^ tog_prev_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tog_prev_r <= 1'b0;
      word_r     <= '0;
    end else begin
      tog_prev_r <= tog_sync;
      if (frame_pulse) begin
        word_r <= frame_hold_r;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:  state_r <= frame_pulse ? ST_EXEC : ST_IDLE;
        ST_EXEC:  state_r <= ST_APPLY;
        ST_APPLY: state_r <= frame_pulse ? ST_EXEC : ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // decode of the captured word
  logic [CHANNELS-1:0] addr_hit;
  logic [CHANNELS-1:0] pwr_sel;
  logic                do_exec;
  logic                is_write;
  logic                is_upd_n;
  logic                is_upd_all;
  logic                is_power;
  logic                is_reset;
  logic                is_mask;
  logic                deep_reset;

  always_comb begin
    addr_hit = '0;
    case (word_r.addr)
      `ADDR_CHAN_A: addr_hit[0] = 1'b1;
      `ADDR_CHAN_B: addr_hit[1] = 1'b1;
      `ADDR_BOTH:   addr_hit    = '1;
      default:      addr_hit    = '0;
    endcase
  end

  assign do_exec    = (state_r == ST_EXEC);
  assign is_write   = do_exec && (word_r.cmd == `CMD_WR_IN || word_r.cmd == `CMD_WR_UPD_ALL ||
                                  word_r.cmd == `CMD_WR_UPD_N);
  assign is_upd_n   = do_exec && (word_r.cmd == `CMD_UPD_OUT || word_r.cmd == `CMD_WR_UPD_N);
  assign is_upd_all = do_exec && (word_r.cmd == `CMD_WR_UPD_ALL);
  assign is_power   = do_exec && (word_r.cmd == `CMD_POWER);
  assign is_reset   = do_exec && (word_r.cmd == `CMD_SOFT_RST);
  assign is_mask    = do_exec && (word_r.cmd == `CMD_MASK_SETUP);
  // reserved code 111 matches none of the above and writes no register; only the masked reload in ST_APPLY follows it
  assign deep_reset = word_r.data[`RST_DEPTH_BIT];
  assign pwr_sel    = {word_r.data[`SEL_B_BIT], word_r.data[`SEL_A_BIT]};

  // per-channel input, output and change tracking
  code_t  [CHANNELS-1:0] in_code_r;
  code_t  [CHANNELS-1:0] out_code_r;
  logic   [CHANNELS-1:0] dirty_r;
  logic   [CHANNELS-1:0] upd_req_r;
  logic   [CHANNELS-1:0] mask_r;
  pmode_t [CHANNELS-1:0] pmode_r;
  logic   [CHANNELS-1:0] copy;

  // the pin acts as a level: while low the output registers stay transparent,
  // a masked channel reloads once per valid frame
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      copy[i] = dirty_r[i] && (!strobe_n_sync || upd_req_r[i] ||
                               (mask_r[i] && state_r == ST_APPLY));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      in_code_r <= '0;
      dirty_r   <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (is_reset) begin
          in_code_r[i] <= `CODE_RST;
          dirty_r[i]   <= 1'b0;
        end else if (is_write && addr_hit[i]) begin
          in_code_r[i] <= word_r.data;
          dirty_r[i]   <= 1'b1;
        end else if (copy[i]) begin
          dirty_r[i]   <= 1'b0;
        end
      end
    end
  end

  // a copy in the same cycle as a write moves the old code; dirty stays set
  // so the new code follows one cycle later
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      out_code_r <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (is_reset) begin
          out_code_r[i] <= `CODE_RST;
        end else if (copy[i]) begin
          out_code_r[i] <= in_code_r[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      upd_req_r <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        upd_req_r[i] <= is_upd_all || (is_upd_n && addr_hit[i]);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mask_r <= `MASK_RST;
    end else if (is_reset && deep_reset) begin
      mask_r <= `MASK_RST;
    end else if (is_mask) begin
      mask_r <= {word_r.data[`SEL_B_BIT], word_r.data[`SEL_A_BIT]};
    end
  end

  // power state never touches the code registers, so power-up restores
  // whatever the output register held
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pmode_r <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (is_reset && deep_reset) begin
          pmode_r[i] <= `PMODE_NORMAL;
        end else if (is_power && pwr_sel[i]) begin
          pmode_r[i] <= word_r.data[`PMODE_HI:`PMODE_LO];
        end
      end
    end
  end

  assign dac_code_out         = out_code_r;
  assign input_code_out       = in_code_r;
  assign power_mode_out       = pmode_r;
  assign sync_update_mask_out = mask_r;

endmodule

`default_nettype wire

/* host_serial.sv */
// serial host model that drives command frames into the converter block
`timescale 1ns/10ps
`default_nettype none
module host_serial (
  output logic sclk_out,
  output logic frame_sel_n_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b1;
    frame_sel_n_out = 1'b1;
    din_out = 1'b0;
  end
  // clock stands high between frames so the first edge in a frame is a falling one
  task automatic send(input logic [23:0] f, input int n, input int half);
    #7.3;
    frame_sel_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      din_out = f[23-i];
      #(half) sclk_out = 1'b0;
      #(half) sclk_out = 1'b1;
    end
    #(half) frame_sel_n_out = 1'b1;
    // released data line shows the inverse so a stale bit is never mistaken for a driven one
    din_out = ~din_out;
  endtask
endmodule
`default_nettype wire

/* tb_dual_dac_command_control.sv */
// self-checking testbench for the converter command block
`timescale 1ns/10ps
`default_nettype none
`include "dac_cmd_cfg.svh"
module tb_dual_dac_command_control;
  import dac_cmd_pkg::*;
  logic             mclk_in = 1'b0;
  logic             rst_in = 1'b0;
  logic             load_strobe_n_in = 1'b1;
  wire logic        sclk, fsel_n, din;
  logic [1:0][15:0] dac_code_out, input_code_out, m_dac, m_in;
  logic [1:0][1:0]  power_mode_out, m_pm;
  logic [1:0]       sync_update_mask_out, m_mask, m_dirty;
  logic [69:0]      exp_q[$];
  logic [69:0]      obs, prev;
  int               errors = 0;
  int               compares = 0;
  int               quiet = 9;
  always #2.5 mclk_in = ~mclk_in;
  host_serial host (.sclk_out(sclk), .frame_sel_n_out(fsel_n), .din_out(din));
  dual_dac_command_control #(.CHANNELS(2)) dut (.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk),
    .frame_sel_n_in(fsel_n), .din_in(din), .load_strobe_n_in(load_strobe_n_in), .dac_code_out(dac_code_out),
    .input_code_out(input_code_out), .power_mode_out(power_mode_out), .sync_update_mask_out(sync_update_mask_out));
  assign obs = {dac_code_out, input_code_out, power_mode_out, sync_update_mask_out};
  task automatic fail(input string msg);
    errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [69:0] snap();
    return {m_dac, m_in, m_pm, m_mask};
  endfunction
  function automatic logic [15:0] r16();
    return 16'($urandom);
  endfunction
  // only channels written since their last copy are reloaded
  task automatic copy(input logic [1:0] ch);
    for (int c = 0; c < 2; c++) begin
      if (ch[c] && m_dirty[c]) begin
        m_dac[c] = m_in[c];
        m_dirty[c] = 1'b0;
      end
    end
  endtask
  task automatic frame(input logic [23:0] w, input int n = 24, input int half = 15);
    frame_s      f;
    logic [69:0] old;
    logic [1:0]  hit;
    f = w;
    old = snap();
    hit = f.addr == `ADDR_BOTH ? 2'h3 : f.addr == `ADDR_CHAN_A ? 2'h1 : f.addr == `ADDR_CHAN_B ? 2'h2 : 2'h0;
    if (n == 24) begin
      if (f.cmd inside {`CMD_WR_IN, `CMD_WR_UPD_ALL, `CMD_WR_UPD_N}) begin
        for (int c = 0; c < 2; c++) begin
          if (hit[c]) begin
            m_in[c] = f.data;
            m_dirty[c] = 1'b1;
          end
        end
      end
      case (f.cmd)
        `CMD_UPD_OUT, `CMD_WR_UPD_N: copy(hit);
        `CMD_WR_UPD_ALL: copy(2'h3);
        `CMD_POWER: for (int c = 0; c < 2; c++) if (f.data[c]) m_pm[c] = f.data[5:4];
        `CMD_SOFT_RST: begin
          {m_dac, m_in, m_dirty} = '0;
          if (f.data[0]) {m_pm, m_mask} = '0;
        end
        `CMD_MASK_SETUP: m_mask = f.data[1:0];
        default: ;
      endcase
      copy(m_mask);
    end
    // the note goes in before the frame, since with a slow serial clock the outputs
    // settle before frame select rises; frames without visible effect leave no note
    if (snap() !== old) exp_q.push_back(snap());
    host.send(w, n, half);
    repeat (14) @(posedge mclk_in);
  endtask
  task automatic strobe(input logic lvl);
    logic [69:0] old;
    old = snap();
    load_strobe_n_in <= lvl;
    if (!lvl) copy(2'h3);
    if (snap() !== old) exp_q.push_back(snap());
    repeat (14) @(posedge mclk_in);
  endtask
  // a result is taken once the outputs have been quiet for four cycles
  always @(posedge mclk_in) begin
    prev <= obs;
    if (rst_in) quiet <= 9;
    else if (obs !== prev) quiet <= 0;
    else if (quiet < 9) quiet <= quiet + 1;
    if (quiet == 4) begin
      compares++;
      if (exp_q.size() == 0) fail("unexpected output change");
      else if (obs !== exp_q.pop_front()) fail("output mismatch");
    end
  end
  initial begin
    // a rising edge at time zero, after the initial low, so the link-side flops see their reset
    rst_in <= 1'b1;
    void'($urandom(32'h01524648));
    {m_dac, m_in, m_pm, m_mask, m_dirty} = '0;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    frame({2'h3, `CMD_WR_IN, `ADDR_CHAN_A, r16()});
    frame({2'h0, `CMD_WR_IN, `ADDR_CHAN_B, r16()}, 24, 40);
    frame({2'h0, `CMD_UPD_OUT, `ADDR_CHAN_A, r16()});
    frame({2'h0, `CMD_UPD_OUT, `ADDR_BOTH, r16()});
    frame({2'h0, `CMD_WR_IN, 3'h2, r16()});
    frame({2'h0, `CMD_WR_IN, `ADDR_CHAN_A, r16()}, 23);
    frame({2'h0, `CMD_RESERVED, `ADDR_BOTH, r16()});
    frame({2'h0, `CMD_WR_UPD_N, `ADDR_BOTH, r16()});
    frame({2'h0, `CMD_WR_UPD_ALL, `ADDR_CHAN_A, r16()});
    for (int m = 1; m < 4; m++) frame({2'h0, `CMD_POWER, 3'h5, 10'($urandom), m[1:0], 2'h0, m[1:0]});
    frame({2'h0, `CMD_POWER, 3'h0, 10'h0, `PMODE_NORMAL, 4'h3});
    frame({2'h0, `CMD_WR_IN, `ADDR_CHAN_B, r16()});
    strobe(1'b0);
    strobe(1'b1);
    frame({2'h0, `CMD_MASK_SETUP, 3'h0, 14'h0, 2'h1});
    frame({2'h0, `CMD_WR_IN, `ADDR_CHAN_A, r16()});
    frame({2'h0, `CMD_WR_IN, `ADDR_CHAN_B, r16()});
    frame({2'h0, `CMD_POWER, 3'h0, 10'h0, `PMODE_HIGH_Z, 4'h2});
    frame({2'h0, `CMD_SOFT_RST, 3'($urandom), 15'($urandom), 1'b0});
    frame({2'h0, `CMD_WR_IN, `ADDR_BOTH, r16()});
    frame({2'h0, `CMD_SOFT_RST, 3'h7, 16'h0001});
    for (int i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge mclk_in);
    if (exp_q.size() != 0) fail("result missing");
    print_verdict();
  end
  initial begin
    #200us;
    fail("timeout");
    print_verdict();
  end
endmodule
`default_nettype wire
